// >>> cal_pkg.sv
// Package with register map, field layout and acquisition constants for the recovery control block
package cal_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_BW_EDGE = 8'h10;
  localparam logic [7:0] REG_SLEW_ADAPT = 8'h13;
  localparam logic [7:0] REG_PHASE = 8'h14;
  localparam logic [7:0] REG_SLICE = 8'h15;
  localparam logic [7:0] REG_TRIM = 8'h73;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int BW_LSB = 0;
  localparam int EDGE_LSB = 3;
  localparam int SLEW_LSB = 0;
  localparam int ADAPT_BIT = 2;
  localparam int PHASE_LSB = 0;
  localparam int SLICE_EXT_BIT = 7;
  localparam logic [2:0] BW_RESET = 3'h4;
  localparam logic [1:0] EDGE_RESET = 2'h0;
  localparam logic [1:0] SLEW_RESET = 2'h2;
  localparam logic ADAPT_RESET = 1'b1;
  localparam logic [3:0] PHASE_RESET = 4'h0;
  localparam logic [7:0] SLICE_RESET = 8'h00;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [6:0] SLICE_OFF_CODE = 7'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // ----------------------------------------------------------------
  // Acquisition thresholds (ppm) and oscillator steps
  // ----------------------------------------------------------------
  localparam logic signed [15:0] LOCK_PPM = 16'sd250;
  localparam logic signed [15:0] UNLOCK_PPM = 16'sd1000;
  localparam logic signed [15:0] COARSE_PPM = 16'sd16000;
  localparam logic signed [15:0] MEDIUM_PPM = 16'sd2000;
  localparam int STEP_COARSE = 64;
  localparam int STEP_MEDIUM = 8;
  localparam int STEP_FINE = 1;

  // Acquisition states, Gray along restart -> seek -> locked
  typedef enum logic [1:0] {
    ACQ_RESTART = 2'b00,
    ACQ_SEEK = 2'b01,
    ACQ_LOCKED = 2'b11
  } cal_acq_e;

  // Host port states
  typedef enum logic [2:0] {
    HP_IDLE = 3'b000,
    HP_ADDR = 3'b001,
    HP_ACK = 3'b011,
    HP_PTR = 3'b010,
    HP_WR = 3'b110,
    HP_RD = 3'b111,
    HP_RACK = 3'b101
  } cal_host_e;

  // Decoded loop configuration handed to the analog and loop datapath
  typedef struct packed {
    logic slice_en;
    logic slice_ext;
    logic [6:0] slice_code;
    logic adapt_slice_en;
    logic edge_rise_only;
    logic edge_fall_only;
    logic [1:0] dll_slew;
    logic [3:0] sample_phase;
    logic [2:0] bw_scale;
  } cal_cfg_s;

endpackage : cal_pkg

// >>> cal_loop_ctrl.sv
// Frequency acquisition machine, two-wire host port and loop configuration decode
`timescale 1ns/100ps

// Functional notes
// - Oscillator/data gap above 1000 ppm raises loss-of-lock and restarts acquisition.
// - Each acquisition starts with oscillator code at bottom and division ratio one.
// - Sampling faster doubles the division ratio; data faster raises oscillator code.
// - Oscillator steps shrink near target; loss-of-lock drops within 250 ppm.
// - Once locked the frequency loop is disabled; phase loops finish the pull.
// - Slice offset comes from bits six to zero of register 0x15.
// - Register 0x73 reads the factory trimmed seven-bit offset, 0.24 mV per count.
// - Normal slice: code 0 disables, 1..127 linear, 64 gives zero offset.
// - Bit 7 widens slice sixfold; 128 disables, 192 is zero offset.
// - Clearing adaptive slice enable in 0x13 stops the offset loop before manual slice.
// - Edge select 1 uses rising edges only, 2 uses falling edges only.
// - Delay-loop slew field in 0x13 resets to 2; tracking is (1+slew)/4 UI.
// - Sample phase is two's complement, 1/32 UI steps, active only at high rates.
// - Bandwidth scale field in 0x10 resets to 4; bandwidth scales by field/4.
// - Default mode programs oscillator and ratio from measurements until within 250 ppm.
module cal_loop_ctrl #(
  parameter int OSC_W = 10,
  parameter int DIV_W = 3,
  parameter logic [6:0] HOST_ADDR = 7'h40
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Two-wire host port, open drain data
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE,
  // Frequency measurement, positive when sampling runs faster than data
  input wire logic FREQ_ERR_VALID,
  input wire logic signed [15:0] FREQ_ERR_PPM,
  // Device state inputs
  input wire logic [6:0] TRIM_OFFSET,
  input wire logic RATE_HIGH,
  // Acquisition outputs
  output logic LOSS_OF_LOCK,
  output logic FLL_EN,
  output logic [OSC_W-1:0] OSC_CODE,
  output logic [DIV_W-1:0] DIV_EXP,
  // Decoded loop configuration
  output cal_pkg::cal_cfg_s LOOP_CFG
);

  // ----------------------------------------------------------------
  // Acquisition machine
  // ----------------------------------------------------------------
  cal_pkg::cal_acq_e acq_ff;
  cal_pkg::cal_acq_e nxt_acq;
  logic [OSC_W-1:0] osc_ff;
  logic [OSC_W-1:0] nxt_osc;
  logic [DIV_W-1:0] div_ff;
  logic [DIV_W-1:0] nxt_div;
  logic lol_ff;
  logic nxt_lol;
  logic signed [16:0] err_mag;
  logic [OSC_W-1:0] step;
  logic [OSC_W:0] osc_sum;
  logic osc_top;
  logic div_top;

  // Magnitude one bit wider, so the most negative reading cannot wrap to a lock; step shrinks near target
  assign err_mag = FREQ_ERR_PPM[15] ? -17'(FREQ_ERR_PPM) : 17'(FREQ_ERR_PPM);
  assign step = (err_mag >= cal_pkg::COARSE_PPM) ? OSC_W'(cal_pkg::STEP_COARSE) :
                (err_mag >= cal_pkg::MEDIUM_PPM) ? OSC_W'(cal_pkg::STEP_MEDIUM) :
                OSC_W'(cal_pkg::STEP_FINE);
  assign osc_sum = {1'b0, osc_ff} + {1'b0, step};
  assign osc_top = osc_sum[OSC_W];
  assign div_top = (div_ff == {DIV_W{1'b1}});

  // Next-state decode; restart moves on to seek at once, seek and locked move only on measurement pulses
  always_comb
  begin
    nxt_acq = acq_ff;
    nxt_osc = osc_ff;
    nxt_div = div_ff;
    nxt_lol = lol_ff;
    unique case (acq_ff)
      cal_pkg::ACQ_RESTART:
      begin
        nxt_osc = '0;
        nxt_div = '0;
        nxt_lol = 1'b1;
        nxt_acq = cal_pkg::ACQ_SEEK;
      end
      cal_pkg::ACQ_SEEK:
        if (FREQ_ERR_VALID)
        begin
          if (err_mag <= cal_pkg::LOCK_PPM)
          begin
            nxt_lol = 1'b0;
            nxt_acq = cal_pkg::ACQ_LOCKED;
          end
          else if (!FREQ_ERR_PPM[15])
          begin
            // Sampling too fast: next octave down, oscillator back to bottom
            if (div_top)
              nxt_acq = cal_pkg::ACQ_RESTART;
            else
            begin
              nxt_div = div_ff + 1'b1;
              nxt_osc = '0;
            end
          end
          else if (osc_top)
            nxt_acq = cal_pkg::ACQ_RESTART; // Range exhausted, try again from the top octave
          else
            nxt_osc = osc_sum[OSC_W-1:0];
        end
      cal_pkg::ACQ_LOCKED:
        if (FREQ_ERR_VALID && err_mag > cal_pkg::UNLOCK_PPM)
        begin
          nxt_lol = 1'b1;
          nxt_acq = cal_pkg::ACQ_RESTART;
        end
      default:
        nxt_acq = cal_pkg::ACQ_RESTART;
    endcase
  end

  // Acquisition registers; reset starts unlocked in a fresh cycle
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      acq_ff <= cal_pkg::ACQ_RESTART;
      osc_ff <= '0;
      div_ff <= '0;
      lol_ff <= 1'b1;
    end
    else
    begin
      acq_ff <= nxt_acq;
      osc_ff <= nxt_osc;
      div_ff <= nxt_div;
      lol_ff <= nxt_lol;
    end
  end

  // Frequency loop runs only while unlocked; phase loops own the oscillator afterwards
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      FLL_EN <= 1'b1;
    else
      FLL_EN <= (nxt_acq != cal_pkg::ACQ_LOCKED);
  end

  assign LOSS_OF_LOCK = lol_ff;
  assign OSC_CODE = osc_ff;
  assign DIV_EXP = div_ff;

  // ----------------------------------------------------------------
  // Host port line sampling and bus conditions
  // ----------------------------------------------------------------
  logic scl_ff;
  logic sda_ff;
  logic scl_d_ff;
  logic sda_d_ff;
  logic bus_start;
  logic bus_stop;
  logic scl_rise;
  logic scl_fall;

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      scl_ff <= 1'b1;
      sda_ff <= 1'b1;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end
    else
    begin
      scl_ff <= SCL_I;
      sda_ff <= SDA_I;
      scl_d_ff <= scl_ff;
      sda_d_ff <= sda_ff;
    end
  end

  // Data moving while the clock is high marks start and stop
  assign bus_start = scl_ff && scl_d_ff && sda_d_ff && !sda_ff;
  assign bus_stop = scl_ff && scl_d_ff && !sda_d_ff && sda_ff;
  assign scl_rise = scl_ff && !scl_d_ff;
  assign scl_fall = !scl_ff && scl_d_ff;

  // ----------------------------------------------------------------
  // Register file and read decode
  // ----------------------------------------------------------------
  logic [2:0] bw_ff;
  logic [1:0] edge_ff;
  logic [1:0] slew_ff;
  logic adapt_ff;
  logic [3:0] phase_ff;
  logic [7:0] slice_ff;
  logic [7:0] ptr_ff;
  logic [7:0] shift_ff;
  logic [7:0] rd_data;
  logic wr_en;

  assign rd_data = (ptr_ff == cal_pkg::REG_BW_EDGE) ? {3'h0, edge_ff, bw_ff} :
                   (ptr_ff == cal_pkg::REG_SLEW_ADAPT) ? {5'h00, adapt_ff, slew_ff} :
                   (ptr_ff == cal_pkg::REG_PHASE) ? {4'h0, phase_ff} :
                   (ptr_ff == cal_pkg::REG_SLICE) ? slice_ff :
                   (ptr_ff == cal_pkg::REG_TRIM) ? {1'b0, TRIM_OFFSET} :
                   cal_pkg::READ_UNMAPPED;

  // ----------------------------------------------------------------
  // Host port byte engine
  // ----------------------------------------------------------------
  cal_pkg::cal_host_e hp_ff;
  cal_pkg::cal_host_e after_ack_ff;
  logic [2:0] bit_ff;
  logic done_ff;
  logic acked_ff;
  logic oe_ff;

  // A complete data byte falling edge in write phase commits it
  assign wr_en = (hp_ff == cal_pkg::HP_WR) && scl_fall && done_ff;

  // Stores writable fields; trim readback and unmapped offsets ignore writes
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      bw_ff <= cal_pkg::BW_RESET;
      edge_ff <= cal_pkg::EDGE_RESET;
      slew_ff <= cal_pkg::SLEW_RESET;
      adapt_ff <= cal_pkg::ADAPT_RESET;
      phase_ff <= cal_pkg::PHASE_RESET;
      slice_ff <= cal_pkg::SLICE_RESET;
    end
    else if (wr_en)
    begin
      if (ptr_ff == cal_pkg::REG_BW_EDGE)
      begin
        bw_ff <= shift_ff[cal_pkg::BW_LSB +: 3];
        edge_ff <= shift_ff[cal_pkg::EDGE_LSB +: 2];
      end
      if (ptr_ff == cal_pkg::REG_SLEW_ADAPT)
      begin
        slew_ff <= shift_ff[cal_pkg::SLEW_LSB +: 2];
        adapt_ff <= shift_ff[cal_pkg::ADAPT_BIT];
      end
      if (ptr_ff == cal_pkg::REG_PHASE)
        phase_ff <= shift_ff[cal_pkg::PHASE_LSB +: 4];
      if (ptr_ff == cal_pkg::REG_SLICE)
        slice_ff <= shift_ff;
    end
  end

  // Byte-level sequencing: address, pointer, then written or read data with auto increment
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      hp_ff <= cal_pkg::HP_IDLE;
      after_ack_ff <= cal_pkg::HP_IDLE;
      bit_ff <= '0;
      done_ff <= 1'b0;
      acked_ff <= 1'b0;
      oe_ff <= 1'b0;
      ptr_ff <= '0;
      shift_ff <= '0;
    end
    else if (bus_start)
    begin
      hp_ff <= cal_pkg::HP_ADDR;
      bit_ff <= '0;
      done_ff <= 1'b0;
      oe_ff <= 1'b0;
    end
    else if (bus_stop)
    begin
      hp_ff <= cal_pkg::HP_IDLE;
      oe_ff <= 1'b0;
    end
    else
      unique case (hp_ff)
        cal_pkg::HP_IDLE:
          oe_ff <= 1'b0;
        cal_pkg::HP_ADDR, cal_pkg::HP_PTR, cal_pkg::HP_WR:
          if (scl_rise)
          begin
            shift_ff <= {shift_ff[6:0], sda_ff};
            bit_ff <= bit_ff + 1'b1;
            done_ff <= (bit_ff == 3'h7);
          end
          else if (scl_fall && done_ff)
          begin
            done_ff <= 1'b0;
            hp_ff <= cal_pkg::HP_ACK;
            oe_ff <= 1'b1; // Acknowledge by pulling data low
            if (hp_ff == cal_pkg::HP_ADDR)
            begin
              if (shift_ff[7:1] != HOST_ADDR)
              begin
                hp_ff <= cal_pkg::HP_IDLE; // Not ours: stay silent until next start
                oe_ff <= 1'b0;
              end
              after_ack_ff <= shift_ff[0] ? cal_pkg::HP_RD : cal_pkg::HP_PTR;
            end
            else if (hp_ff == cal_pkg::HP_PTR)
            begin
              ptr_ff <= shift_ff;
              after_ack_ff <= cal_pkg::HP_WR;
            end
            else
            begin
              ptr_ff <= ptr_ff + 1'b1;
              after_ack_ff <= cal_pkg::HP_WR;
            end
          end
        cal_pkg::HP_ACK:
          if (scl_fall)
          begin
            hp_ff <= after_ack_ff;
            bit_ff <= '0;
            if (after_ack_ff == cal_pkg::HP_RD)
            begin
              shift_ff <= rd_data;
              oe_ff <= !rd_data[7];
            end
            else
              oe_ff <= 1'b0;
          end
        cal_pkg::HP_RD:
          if (scl_rise)
          begin
            bit_ff <= bit_ff + 1'b1;
            done_ff <= (bit_ff == 3'h7);
          end
          else if (scl_fall)
          begin
            if (done_ff)
            begin
              done_ff <= 1'b0;
              acked_ff <= 1'b0;
              oe_ff <= 1'b0; // Release for the controller's acknowledge
              hp_ff <= cal_pkg::HP_RACK;
            end
            else
            begin
              shift_ff <= {shift_ff[6:0], 1'b0};
              oe_ff <= !shift_ff[6];
            end
          end
        cal_pkg::HP_RACK:
          if (scl_rise)
          begin
            if (sda_ff)
              hp_ff <= cal_pkg::HP_IDLE; // Not acknowledged: read ends
            else
            begin
              acked_ff <= 1'b1;
              ptr_ff <= ptr_ff + 1'b1;
            end
          end
          else if (scl_fall && acked_ff)
          begin
            hp_ff <= cal_pkg::HP_RD;
            bit_ff <= '0;
            shift_ff <= rd_data;
            oe_ff <= !rd_data[7];
          end
        default:
          hp_ff <= cal_pkg::HP_IDLE;
      endcase
  end

  assign SDA_OE = oe_ff;

  // Data line is only ever pulled low; the level register keeps the output flop-driven
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      SDA_O <= 1'b0;
    else
      SDA_O <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Loop configuration decode
  // ----------------------------------------------------------------
  // Registered so the analog controls change cleanly one cycle after a write.
  // A zero bandwidth field is passed through: software is trusted not to open the loop.
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      LOOP_CFG <= '0;
    else
    begin
      LOOP_CFG.slice_en <= (slice_ff[6:0] != cal_pkg::SLICE_OFF_CODE);
      LOOP_CFG.slice_ext <= slice_ff[cal_pkg::SLICE_EXT_BIT];
      LOOP_CFG.slice_code <= slice_ff[6:0];
      LOOP_CFG.adapt_slice_en <= adapt_ff;
      LOOP_CFG.edge_rise_only <= (edge_ff == cal_pkg::EDGE_RISE);
      LOOP_CFG.edge_fall_only <= (edge_ff == cal_pkg::EDGE_FALL);
      LOOP_CFG.dll_slew <= slew_ff;
      LOOP_CFG.sample_phase <= RATE_HIGH ? phase_ff : cal_pkg::PHASE_RESET;
      LOOP_CFG.bw_scale <= bw_ff;
    end
  end

endmodule : cal_loop_ctrl

// >>> cal_loop_ctrl_assertions.sv
// Port-level assertions for the recovery loop control block
`timescale 1ns/100ps
module cal_loop_ctrl_assertions #(
  parameter int OSC_W = 10,
  parameter int DIV_W = 3
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Host port
  input wire logic SCL_I,
  input wire logic SDA_I,
  input wire logic SDA_O,
  input wire logic SDA_OE,
  // Measurement and device inputs
  input wire logic FREQ_ERR_VALID,
  input wire logic signed [15:0] FREQ_ERR_PPM,
  input wire logic [6:0] TRIM_OFFSET,
  input wire logic RATE_HIGH,
  // Outputs under check
  input wire logic LOSS_OF_LOCK,
  input wire logic FLL_EN,
  input wire logic [OSC_W-1:0] OSC_CODE,
  input wire logic [DIV_W-1:0] DIV_EXP,
  input wire cal_pkg::cal_cfg_s LOOP_CFG
);
  // ------
  // Helper logic
  // ------
  logic [OSC_W:0] osc_sum;
  logic [OSC_W-1:0] osc_exp_ff;
  logic [DIV_W-1:0] div_exp_ff;
  logic far_err;
  logic near_err;
  logic redo_ff;
  // Step shrinks near the target; the top bit flags an overflow, which restarts instead
  assign osc_sum = {1'b0, OSC_CODE} + (
    (FREQ_ERR_PPM <= -cal_pkg::COARSE_PPM) ? (OSC_W+1)'(cal_pkg::STEP_COARSE) :
    (FREQ_ERR_PPM <= -cal_pkg::MEDIUM_PPM) ? (OSC_W+1)'(cal_pkg::STEP_MEDIUM) : (OSC_W+1)'(cal_pkg::STEP_FINE));
  assign far_err = (FREQ_ERR_PPM > cal_pkg::UNLOCK_PPM) || (FREQ_ERR_PPM < -cal_pkg::UNLOCK_PPM);
  assign near_err = (FREQ_ERR_PPM <= cal_pkg::LOCK_PPM) && (FREQ_ERR_PPM >= -cal_pkg::LOCK_PPM);
  // Codes expected in the cycle after a measurement
  always_ff @(posedge CLK)
  begin
    osc_exp_ff <= osc_sum[OSC_W-1:0];
    div_exp_ff <= DIV_EXP + DIV_W'(1);
  end
  // A measurement that exhausts the ratio or the oscillator range is followed by a restart cycle
  always_ff @(posedge CLK)
  begin
    redo_ff <= !SYS_RST && LOSS_OF_LOCK && FREQ_ERR_VALID &&
      ((FREQ_ERR_PPM > cal_pkg::LOCK_PPM && DIV_EXP == '1) || (FREQ_ERR_PPM < -cal_pkg::LOCK_PPM && osc_sum[OSC_W]));
  end
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);
  // A measurement that the seek state honours; the restart cycle ignores pulses
  sequence s_seek;
    LOSS_OF_LOCK && FREQ_ERR_VALID && !$rose(LOSS_OF_LOCK) && !$fell(SYS_RST) && !redo_ff;
  endsequence
  // ------
  // Properties
  // ------
  property p_reset_state;
    $fell(SYS_RST) |-> LOSS_OF_LOCK && FLL_EN && OSC_CODE == '0 && DIV_EXP == '0 && !SDA_OE;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset state wrong");
  property p_defaults;
    $fell(SYS_RST) |-> ##1 LOOP_CFG.bw_scale == cal_pkg::BW_RESET && LOOP_CFG.dll_slew == cal_pkg::SLEW_RESET;
  endproperty
  a_defaults: assert property (p_defaults) else $error("field defaults wrong");
  property p_loss;
    !LOSS_OF_LOCK && FREQ_ERR_VALID && far_err |=> LOSS_OF_LOCK && FLL_EN;
  endproperty
  a_loss: assert property (p_loss) else $error("lock not dropped");
  property p_restart;
    $rose(LOSS_OF_LOCK) |-> ##[0:1] OSC_CODE == '0 && DIV_EXP == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("restart codes wrong");
  property p_double;
    s_seek ##0 (FREQ_ERR_PPM > cal_pkg::LOCK_PPM && DIV_EXP != '1) |=> DIV_EXP == div_exp_ff && OSC_CODE == '0;
  endproperty
  a_double: assert property (p_double) else $error("ratio not doubled");
  property p_step;
    s_seek ##0 (FREQ_ERR_PPM < -cal_pkg::LOCK_PPM && !osc_sum[OSC_W]) |=> OSC_CODE == osc_exp_ff && LOSS_OF_LOCK;
  endproperty
  a_step: assert property (p_step) else $error("oscillator step wrong");
  property p_lock;
    s_seek ##0 near_err |=> !LOSS_OF_LOCK && !FLL_EN;
  endproperty
  a_lock: assert property (p_lock) else $error("lock not taken");
  property p_fll;
    FLL_EN == LOSS_OF_LOCK;
  endproperty
  a_fll: assert property (p_fll) else $error("frequency loop state wrong");
  property p_slice;
    LOOP_CFG.slice_en == (LOOP_CFG.slice_code != cal_pkg::SLICE_OFF_CODE);
  endproperty
  a_slice: assert property (p_slice) else $error("slice enable wrong");
  property p_phase;
    !RATE_HIGH ##1 !RATE_HIGH |-> LOOP_CFG.sample_phase == '0;
  endproperty
  a_phase: assert property (p_phase) else $error("phase not gated");
  c_lock: cover property ($fell(LOSS_OF_LOCK));
  c_loss: cover property ($rose(LOSS_OF_LOCK));
  c_ack: cover property ($rose(SDA_OE));
endmodule : cal_loop_ctrl_assertions

bind cal_loop_ctrl cal_loop_ctrl_assertions #(.OSC_W(OSC_W), .DIV_W(DIV_W)) chk_u (
  .CLK(CLK), .SYS_RST(SYS_RST), .SCL_I(SCL_I), .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE(SDA_OE),
  .FREQ_ERR_VALID(FREQ_ERR_VALID), .FREQ_ERR_PPM(FREQ_ERR_PPM), .TRIM_OFFSET(TRIM_OFFSET),
  .RATE_HIGH(RATE_HIGH), .LOSS_OF_LOCK(LOSS_OF_LOCK), .FLL_EN(FLL_EN), .OSC_CODE(OSC_CODE),
  .DIV_EXP(DIV_EXP), .LOOP_CFG(LOOP_CFG));

// >>> cal_host_model.sv
// Two-wire host controller model for the recovery block's host port
`timescale 1ns/100ps
module cal_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h40
) (
  // Clock
  input wire logic CLK,
  // Two-wire lines
  output logic SCL,
  output wire logic SDA,
  input wire logic SDA_OE
);
  // ------
  // Line state
  // ------
  logic sda_drv = 1'b1;
  int nacks = 0;
  // Pull-up wire: high unless some party pulls it low
  assign SDA = sda_drv & ~SDA_OE;
  initial SCL = 1'b1;
  // ------
  // Bus cycles
  // ------
  // Data moves mid-low and stands through the whole high phase
  task automatic bit_xfer(input logic b, output logic r);
    repeat (3) @(negedge CLK);
    sda_drv = b;
    repeat (3) @(negedge CLK);
    SCL = 1'b1;
    repeat (6) @(negedge CLK);
    r = SDA;
    SCL = 1'b0;
  endtask : bit_xfer
  // Start is 1 to 0 with clock high, stop 0 to 1; clock is left at the new level
  task automatic cond(input logic a, input logic b);
    repeat (3) @(negedge CLK);
    sda_drv = a;
    repeat (3) @(negedge CLK);
    SCL = 1'b1;
    repeat (6) @(negedge CLK);
    sda_drv = b;
    repeat (6) @(negedge CLK);
    SCL = b;
  endtask : cond
  // Eight bits then acknowledge; a missing device acknowledge is counted
  task automatic byte_xfer(input logic [7:0] d, input logic last, output logic [7:0] q);
    logic a;
    for (int i = 7; i >= 0; i--)
      bit_xfer(d[i], q[i]);
    bit_xfer(1'b1, a);
    if (!last && a)
      nacks++;
  endtask : byte_xfer
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    logic [7:0] q;
    cond(1'b1, 1'b0);
    byte_xfer({DEV_ADDR, 1'b0}, 1'b0, q);
    byte_xfer(ptr, 1'b0, q);
    byte_xfer(d, 1'b0, q);
    cond(1'b0, 1'b1);
  endtask : wr
  // Pointer set, repeated start, one byte closed with a refusal
  task automatic rd(input logic [7:0] ptr, output logic [7:0] d);
    logic [7:0] q;
    cond(1'b1, 1'b0);
    byte_xfer({DEV_ADDR, 1'b0}, 1'b0, q);
    byte_xfer(ptr, 1'b0, q);
    cond(1'b1, 1'b0);
    byte_xfer({DEV_ADDR, 1'b1}, 1'b0, q);
    byte_xfer(8'hff, 1'b1, d);
    cond(1'b0, 1'b1);
  endtask : rd
endmodule : cal_host_model

// >>> cal_loop_ctrl_tb.sv
// Self-checking testbench for the recovery loop control block
`timescale 1ns/100ps
module cal_loop_ctrl_tb;
  // ------
  // Signals and tables
  // ------
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic scl;
  logic sda;
  logic sda_o;
  logic sda_oe;
  logic err_vld = 1'b0;
  logic signed [15:0] err_ppm = 16'h0000;
  logic [6:0] trim = 7'h2b;
  logic rate_high = 1'b1;
  logic loss_of_lock;
  logic fll_en;
  logic [9:0] osc;
  logic [2:0] div;
  cal_pkg::cal_cfg_s cfg;
  logic [7:0] sh [256];
  logic [7:0] q;
  int num_errors = 0;
  int comparisons = 0;
  // Offset and data; adapt cleared before manual slice, slew once zero, bandwidth never zero
  logic [15:0] wt [14] = '{16'h100c, 16'h1017, 16'h1001, 16'h1302, 16'h1300, 16'h140f, 16'h1408,
    16'h1540, 16'h1500, 16'h1580, 16'h15c0, 16'h15ff, 16'h7355, 16'h205a};
  // Error in ppm and the {lock loss, ratio, oscillator} seen after it
  logic [31:0] mt [7] = '{32'h1388_2400, 32'hb1e0_2440, 32'hec78_2448, 32'hfe0c_2449,
    32'hff06_0449, 32'h03e8_0449, 32'h03e9_2000};
  always #10 clk = ~clk;
  cal_loop_ctrl #(.OSC_W(10), .DIV_W(3), .HOST_ADDR(7'h40)) dut_u (
    .CLK(clk), .SYS_RST(sys_rst), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe),
    .FREQ_ERR_VALID(err_vld), .FREQ_ERR_PPM(err_ppm), .TRIM_OFFSET(trim), .RATE_HIGH(rate_high),
    .LOSS_OF_LOCK(loss_of_lock), .FLL_EN(fll_en), .OSC_CODE(osc), .DIV_EXP(div), .LOOP_CFG(cfg));
  cal_host_model #(.DEV_ADDR(7'h40)) hm_u (.CLK(clk), .SCL(scl), .SDA(sda), .SDA_OE(sda_oe));
  // ------
  // Checking
  // ------
  task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Decoded fields follow the shadow copy of each register
  task automatic chk_cfg;
    chk("slice_code", sh[8'h15][6:0], cfg.slice_code);
    chk("slice_ext", sh[8'h15][7], cfg.slice_ext);
    chk("slice_en", sh[8'h15][6:0] != 7'h00, cfg.slice_en);
    chk("adapt", sh[8'h13][2], cfg.adapt_slice_en);
    chk("slew", sh[8'h13][1:0], cfg.dll_slew);
    chk("rise", sh[8'h10][4:3] == 2'h1, cfg.edge_rise_only);
    chk("fall", sh[8'h10][4:3] == 2'h2, cfg.edge_fall_only);
    chk("phase", rate_high ? sh[8'h14][3:0] : 4'h0, cfg.sample_phase);
    chk("bw", sh[8'h10][2:0], cfg.bw_scale);
  endtask : chk_cfg
  task automatic results;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results
  // ------
  // Main sequence
  // ------
  initial
  begin
    repeat (12) @(negedge clk);
    sys_rst = 1'b0;
    chk("reset_state", 16'h2000, {loss_of_lock, div, osc});
    chk("reset_fll", 1'b1, fll_en);
    sh = '{default: 8'h00};
    sh[8'h10] = 8'h04;
    sh[8'h13] = 8'h06;
    sh[8'h73] = {1'b0, trim};
    repeat (2) @(negedge clk);
    chk_cfg();
    // Read before and after each write; read-only and unmapped places keep their value
    for (int i = 0; i < 14; i++)
    begin
      hm_u.rd(wt[i][15:8], q);
      chk("read_before", sh[wt[i][15:8]], q);
      hm_u.wr(wt[i][15:8], wt[i][7:0]);
      if (wt[i][15:8] inside {8'h10, 8'h13, 8'h14, 8'h15})
        sh[wt[i][15:8]] = wt[i][7:0];
      hm_u.rd(wt[i][15:8], q);
      chk("read_after", sh[wt[i][15:8]], q);
      chk_cfg();
    end
    chk("nacks", 20'h00000, hm_u.nacks);
    chk("sda_o", 1'b0, sda_o);
    rate_high = 1'b0;
    repeat (3) @(negedge clk);
    chk_cfg();
    // Acquisition: doubling, shrinking steps, lock at 250, hold at 1000, loss past 1000
    for (int i = 0; i < 7; i++)
    begin
      err_ppm = mt[i][31:16];
      err_vld = 1'b1;
      @(negedge clk);
      err_vld = 1'b0;
      @(negedge clk);
      chk("lol_div_osc", mt[i][15:0], {loss_of_lock, div, osc});
      chk("fll_en", mt[i][13], fll_en);
    end
    results();
  end
  // Watchdog: a hang counts as a mismatch
  initial
  begin
    repeat (100000) @(posedge clk);
    num_errors++;
    results();
  end
endmodule : cal_loop_ctrl_tb
